// ---- src/rcs_pkg.sv ----
// constants, register layout and carrier tables for the respiration carrier select block
package rcs_pkg;
	// register offsets on the register port
	localparam logic [5:0] RCS_ACQ_CTL_ADDR = 6'h01;
	localparam logic [5:0] RCS_RESP_CTL_ADDR = 6'h03;
	localparam logic [5:0] RCS_EXT_SW_ADDR = 6'h0a;
	localparam logic [31:0] RCS_REG_RESET = 32'h0000_0000;
	// field positions
	localparam int RCS_AC_HP_BIT = 3;
	localparam int RCS_RC_FREQ_LO = 1;
	localparam int RCS_RC_ALT_BIT = 3;
	localparam int RCS_RC_XSYNC_BIT = 4;
	localparam int RCS_RC_SYNCEN_BIT = 7;
	localparam int RCS_SW_ONE_BIT = 0;
	localparam int RCS_SW_NUM = 3;
	// clock rate in Hz and carrier frequencies in units of 100 Hz
	localparam int RCS_CLK_HZ = 50_000_000;
	localparam int RCS_UNIT_HZ = 100;
	localparam int RCS_F_640 = 640;
	localparam int RCS_F_569 = 569;
	localparam int RCS_F_560 = 560;
	localparam int RCS_F_540 = 540;
	localparam int RCS_F_520 = 520;
	localparam int RCS_F_512 = 512;
	localparam int RCS_F_500 = 500;
	localparam int RCS_F_465 = 465;
	localparam int RCS_F_320 = 320;
	localparam int RCS_F_280 = 280;
	localparam int RCS_F_255 = 255;
	localparam int RCS_F_230 = 230;
	localparam int RCS_HALF_W = 12;
	typedef logic [RCS_HALF_W-1:0] rcs_half_t;
	// half period in clock cycles, rounded down so the carrier never runs slow
	function automatic rcs_half_t rcs_half(input int f_units);
		rcs_half = rcs_half_t'(RCS_CLK_HZ / (2 * f_units * RCS_UNIT_HZ));
	endfunction : rcs_half
	localparam rcs_half_t RCS_H_640 = rcs_half(RCS_F_640);
	localparam rcs_half_t RCS_H_569 = rcs_half(RCS_F_569);
	localparam rcs_half_t RCS_H_560 = rcs_half(RCS_F_560);
	localparam rcs_half_t RCS_H_540 = rcs_half(RCS_F_540);
	localparam rcs_half_t RCS_H_520 = rcs_half(RCS_F_520);
	localparam rcs_half_t RCS_H_512 = rcs_half(RCS_F_512);
	localparam rcs_half_t RCS_H_500 = rcs_half(RCS_F_500);
	localparam rcs_half_t RCS_H_465 = rcs_half(RCS_F_465);
	localparam rcs_half_t RCS_H_320 = rcs_half(RCS_F_320);
	localparam rcs_half_t RCS_H_280 = rcs_half(RCS_F_280);
	localparam rcs_half_t RCS_H_255 = rcs_half(RCS_F_255);
	localparam rcs_half_t RCS_H_230 = rcs_half(RCS_F_230);
	localparam rcs_half_t RCS_H_ONE = 12'h001;
	// register read and write request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [31:0] wdata;
	} rcs_req_t;
	// divider state
	typedef struct packed {
		rcs_half_t cnt;
		rcs_half_t half;
		logic out;
	} rcs_div_t;
endpackage : rcs_pkg

// ---- src/rcs_divider.sv ----
// square wave generator whose half period is set in clock cycles
`timescale 1ns/1ns
module rcs_divider
	import rcs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic en,
	input wire rcs_half_t half,
	output logic wave
);
	rcs_div_t st_r;
	rcs_div_t st_nxt;

	// restart on a new period so the first edge after a change is clean
	always_comb begin
		st_nxt = st_r;
		if (!en) begin
			st_nxt.cnt = '0;
			st_nxt.out = 1'b0;
			st_nxt.half = half;
		end else if (half != st_r.half) begin
			st_nxt.cnt = '0;
			st_nxt.half = half;
		end else if (st_r.cnt >= st_r.half - RCS_H_ONE) begin
			st_nxt.cnt = '0;
			st_nxt.out = !st_r.out;
		end else begin
			st_nxt.cnt = st_r.cnt + RCS_H_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign wave = st_r.out;
endmodule : rcs_divider

// ---- src/rcs_top.sv ----
// respiration carrier frequency select, sync pin output and extend switches
`timescale 1ns/1ns
// Functional notes
// - carrier set by code, alt, sync bits
// - high performance bit also steers carrier
// - alt clear gives 56/54/52/50 kHz
// - alt, hp, no sync: 64/56.9/51.2/46.5
// - alt without hp: 32/28/25.5/23 kHz
// - bit 7 drives sync pin table wave on pin three
// - each extend switch set as programmed
module rcs_top
	import rcs_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire rcs_req_t req,
	output logic [31:0] rdata,
	output logic rvalid,
	output logic carrier_out,
	output logic general_pin_three_out,
	output logic general_pin_three_oe,
	output logic extend_switch_one,
	output logic extend_switch_two,
	output logic extend_switch_three
);
	typedef struct packed {
		logic [31:0] acq;
		logic [31:0] resp;
		logic [RCS_SW_NUM-1:0] sw;
		logic [31:0] rdata;
		logic rvalid;
	} rcs_state_t;

	rcs_state_t st_r;
	rcs_state_t st_nxt;
	rcs_half_t carrier_half;
	rcs_half_t pin_half;
	logic [1:0] carrier_freq_code;
	logic alt_freq_bank;
	logic carrier_sync_out_sel;
	logic high_perf_mode;
	logic sync_out_enable;

	// control fields
	assign carrier_freq_code = st_r.resp[RCS_RC_FREQ_LO +: 2];
	assign alt_freq_bank = st_r.resp[RCS_RC_ALT_BIT];
	assign carrier_sync_out_sel = st_r.resp[RCS_RC_XSYNC_BIT];
	assign sync_out_enable = st_r.resp[RCS_RC_SYNCEN_BIT];
	assign high_perf_mode = st_r.acq[RCS_AC_HP_BIT];

	// register port: writes and registered reads, unmapped reads as zero
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = req.rd;
		if (req.wr) begin
			case (req.addr)
				RCS_ACQ_CTL_ADDR: st_nxt.acq = req.wdata;
				RCS_RESP_CTL_ADDR: st_nxt.resp = req.wdata;
				RCS_EXT_SW_ADDR: st_nxt.sw = req.wdata[RCS_SW_ONE_BIT +: RCS_SW_NUM];
				default: st_nxt.rvalid = req.rd;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				RCS_ACQ_CTL_ADDR: st_nxt.rdata = st_r.acq;
				RCS_RESP_CTL_ADDR: st_nxt.rdata = st_r.resp;
				RCS_EXT_SW_ADDR: st_nxt.rdata = {29'h0000_0000, st_r.sw};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r.acq <= RCS_REG_RESET;
			st_r.resp <= RCS_REG_RESET;
			st_r.sw <= '0;
			st_r.rdata <= 32'h0000_0000;
			st_r.rvalid <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// internal carrier; with sync selected the high bank follows the pin table
	always_comb begin
		carrier_half = RCS_H_560;
		if (!alt_freq_bank) begin
			case (carrier_freq_code)
				2'h0: carrier_half = RCS_H_560;
				2'h1: carrier_half = RCS_H_540;
				2'h2: carrier_half = RCS_H_520;
				default: carrier_half = RCS_H_500;
			endcase
		end else if (high_perf_mode) begin
			case (carrier_freq_code)
				2'h0: carrier_half = RCS_H_640;
				2'h1: carrier_half = carrier_sync_out_sel ? RCS_H_560 : RCS_H_569;
				2'h2: carrier_half = RCS_H_512;
				default: carrier_half = RCS_H_465;
			endcase
		end else begin
			case (carrier_freq_code)
				2'h0: carrier_half = RCS_H_320;
				2'h1: carrier_half = RCS_H_280;
				2'h2: carrier_half = RCS_H_255;
				default: carrier_half = RCS_H_230;
			endcase
		end
	end

	// frequency presented on pin three for an external generator to lock to
	always_comb begin
		pin_half = RCS_H_640;
		if (alt_freq_bank) begin
			case (carrier_freq_code)
				2'h0: pin_half = high_perf_mode ? RCS_H_640 : RCS_H_320;
				2'h1: pin_half = high_perf_mode ? RCS_H_560 : RCS_H_280;
				2'h2: pin_half = high_perf_mode ? RCS_H_512 : RCS_H_255;
				default: pin_half = high_perf_mode ? RCS_H_465 : RCS_H_230;
			endcase
		end
	end

	rcs_divider u_carrier (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.en(1'b1),
		.half(carrier_half),
		.wave(carrier_out)
	);

	// pin generator held low while the sync output is off
	rcs_divider u_pin (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.en(sync_out_enable),
		.half(pin_half),
		.wave(general_pin_three_out)
	);

	// the switch state lives in flops; the analog mux follows them directly
	assign rdata = st_r.rdata;
	assign rvalid = st_r.rvalid;
	assign general_pin_three_oe = sync_out_enable;
	assign extend_switch_one = st_r.sw[0];
	assign extend_switch_two = st_r.sw[1];
	assign extend_switch_three = st_r.sw[2];

	chk_resp_reg_write: assert property (@(posedge clk) disable iff (srst)
		(ce && req.wr && req.addr == RCS_RESP_CTL_ADDR) |=> st_r.resp == $past(req.wdata))
		else $error("respiration control write lost");
	chk_acq_reg_write: assert property (@(posedge clk) disable iff (srst)
		(ce && req.wr && req.addr == RCS_ACQ_CTL_ADDR)
		|=> high_perf_mode == $past(req.wdata[RCS_AC_HP_BIT]))
		else $error("high performance bit not taken");
	chk_base_bank: assert property (@(posedge clk) disable iff (srst)
		(!alt_freq_bank && carrier_freq_code == 2'h3) |-> carrier_half == RCS_H_500)
		else $error("base bank frequency wrong");
	chk_hp_bank: assert property (@(posedge clk) disable iff (srst)
		(alt_freq_bank && high_perf_mode && !carrier_sync_out_sel && carrier_freq_code == 2'h1)
		|-> carrier_half == RCS_H_569)
		else $error("high performance bank frequency wrong");
	chk_low_bank: assert property (@(posedge clk) disable iff (srst)
		(alt_freq_bank && !high_perf_mode && carrier_freq_code == 2'h2) |-> carrier_half == RCS_H_255)
		else $error("low power bank frequency wrong");
	chk_pin_off: assert property (@(posedge clk) disable iff (srst)
		(ce && !sync_out_enable) |=> !general_pin_three_out)
		else $error("pin three toggles while sync output is off");
	chk_pin_freq: assert property (@(posedge clk) disable iff (srst)
		!alt_freq_bank |-> pin_half == RCS_H_640)
		else $error("sync pin frequency wrong");
	chk_switch_map: assert property (@(posedge clk) disable iff (srst)
		(ce && req.wr && req.addr == RCS_EXT_SW_ADDR)
		|=> {extend_switch_three, extend_switch_two, extend_switch_one}
		== $past(req.wdata[RCS_SW_ONE_BIT +: RCS_SW_NUM]))
		else $error("extend switches differ from programmed value");

	// read answer comes one cycle after the strobe and lasts one cycle only
	chk_read_answer: assert property (@(posedge clk) disable iff (srst)
		(ce && req.rd) |=> rvalid)
		else $error("read answer missing");
	chk_read_pulse: assert property (@(posedge clk) disable iff (srst)
		(ce && !req.rd) |=> !rvalid)
		else $error("read answer held too long");

	// pin enable is bit 7 of the written respiration control word
	chk_oe_write: assert property (@(posedge clk) disable iff (srst)
		(ce && req.wr && req.addr == RCS_RESP_CTL_ADDR)
		|=> general_pin_three_oe == $past(req.wdata[RCS_RC_SYNCEN_BIT]))
		else $error("sync output enable not taken");

	// low bank ignores sync select, so carrier and pin tables must agree
	chk_low_sync_free: assert property (@(posedge clk) disable iff (srst)
		(alt_freq_bank && !high_perf_mode) |-> carrier_half == pin_half)
		else $error("sync select changed the low bank carrier");

	// base bank first code whatever the performance mode
	chk_base_first: assert property (@(posedge clk) disable iff (srst)
		(!alt_freq_bank && carrier_freq_code == 2'h0) |-> carrier_half == RCS_H_560)
		else $error("base bank first code wrong");

	// pin table rounds the second high bank code to a plain value
	chk_pin_hp_code: assert property (@(posedge clk) disable iff (srst)
		(alt_freq_bank && high_perf_mode && carrier_freq_code == 2'h1)
		|-> pin_half == RCS_H_560)
		else $error("sync pin high bank frequency wrong");

	// switches move only on a write to their own register
	chk_switch_hold: assert property (@(posedge clk) disable iff (srst)
		!(ce && req.wr && req.addr == RCS_EXT_SW_ADDR)
		|=> $stable({extend_switch_three, extend_switch_two, extend_switch_one}))
		else $error("extend switches moved without a write");

	// a low clock enable must freeze the carrier as well as the registers
	chk_ce_freeze: assert property (@(posedge clk) disable iff (srst)
		!ce |=> $stable(carrier_out))
		else $error("carrier moved with clock enable low");
endmodule : rcs_top

// ---- bench/rcs_host.sv ----
// host model that writes and reads registers on the register port
`timescale 1ns/1ns
module rcs_host
	import rcs_pkg::*;
(
	input wire logic clk,
	output rcs_req_t req,
	input wire logic [31:0] rdata,
	input wire logic rvalid
);
	initial req = '0;
	// one-cycle write strobe; released lines are scrambled so stale data never helps
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr
	// read answer sampled one cycle after the strobe is driven, half a cycle after it is taken
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic v);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
		d = rdata;
		v = rvalid;
	endtask : rd
endmodule : rcs_host

// ---- bench/rcs_top_tb.sv ----
// self-checking bench for the carrier select, sync pin and extend switches
`timescale 1ns/1ns
module rcs_top_tb
	import rcs_pkg::*;
;
	logic clk = 0, srst = 1, ce = 1;
	rcs_req_t req;
	logic [31:0] rdata;
	logic rvalid, car, g3, g3oe, s1, s2, s3;
	int n_mismatch = 0, checks_done = 0;
	always #10 clk = ~clk;
	rcs_top DUT(.clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
		.carrier_out(car), .general_pin_three_out(g3), .general_pin_three_oe(g3oe),
		.extend_switch_one(s1), .extend_switch_two(s2), .extend_switch_three(s3));
	rcs_host host(.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	// expected carrier in 100 Hz units; pin selects the sync pin table
	function automatic int exp_f(logic alt, logic hp, logic sy, logic pin, logic [1:0] c);
		if (pin && !alt) return RCS_F_640;
		if (!alt) return c == 0 ? RCS_F_560 : c == 1 ? RCS_F_540 : c == 2 ? RCS_F_520 : RCS_F_500;
		if (!hp) return c == 0 ? RCS_F_320 : c == 1 ? RCS_F_280 : c == 2 ? RCS_F_255 : RCS_F_230;
		if (c == 1) return (pin || sy) ? RCS_F_560 : RCS_F_569;
		return c == 0 ? RCS_F_640 : c == 2 ? RCS_F_512 : RCS_F_465;
	endfunction : exp_f
	function automatic int half(int f);
		return RCS_CLK_HZ / (2 * f * RCS_UNIT_HZ);
	endfunction : half
	// one full level measured between two toggles, bounded in case the wave stalls
	task automatic meas(input bit pin, output int h);
		logic v;
		int n;
		n = 0;
		h = 0;
		v = pin ? g3 : car;
		while ((pin ? g3 : car) === v && n < 3000) begin
			@(negedge clk);
			n++;
		end
		v = pin ? g3 : car;
		while ((pin ? g3 : car) === v && h < 3000) begin
			@(negedge clk);
			h++;
		end
	endtask : meas
	initial begin
		#(20 * 90000);
		n_mismatch++;
		summarize();
	end
	initial begin
		logic [31:0] d;
		logic v;
		logic [4:0] cfg;
		logic [31:0] aw;
		logic [2:0] sw;
		logic [5:0] adr [4];
		int h;
		adr = '{RCS_ACQ_CTL_ADDR, RCS_RESP_CTL_ADDR, RCS_EXT_SW_ADDR, 6'h3f};
		void'($urandom(32'hc01a644c));
		repeat (5) @(negedge clk);
		srst = 0;
		// reset values, unmapped place included
		for (int i = 0; i < 4; i++) begin
			host.rd(adr[i], d, v);
			chk(v, 32'h1);
			chk(d, RCS_REG_RESET);
		end
		@(negedge clk);
		chk(rvalid, 32'h0);
		// random switch patterns, settle before use
		repeat (8) begin
			sw = 3'($urandom);
			host.wr(RCS_EXT_SW_ADDR, {29'($urandom), sw});
			repeat (2) @(negedge clk);
			chk({s3, s2, s1}, sw);
			host.rd(RCS_EXT_SW_ADDR, d, v);
			chk(d, {29'h0, sw});
		end
		// a write with clock enable low must not land
		ce = 0;
		host.wr(RCS_EXT_SW_ADDR, {29'h0, ~sw});
		ce = 1;
		chk({s3, s2, s1}, sw);
		// every code, bank, performance and sync select setting
		for (int i = 0; i < 32; i++) begin
			cfg = 5'(i);
			aw = {28'($urandom), cfg[3], 3'($urandom)};
			host.wr(RCS_ACQ_CTL_ADDR, aw);
			host.wr(RCS_RESP_CTL_ADDR, {24'h0, 1'b1, 2'b00, cfg[4], cfg[2], cfg[1:0], 1'b0});
			repeat (3) @(negedge clk);
			chk(g3oe, 32'h1);
			meas(0, h);
			chk(h, half(exp_f(cfg[2], cfg[3], cfg[4], 0, cfg[1:0])));
			if (cfg[4]) begin
				meas(1, h);
				chk(h, half(exp_f(cfg[2], cfg[3], 1, 1, cfg[1:0])));
			end
			host.rd(RCS_ACQ_CTL_ADDR, d, v);
			chk(d, aw);
			host.rd(RCS_RESP_CTL_ADDR, d, v);
			chk(d, {24'h0, 1'b1, 2'b00, cfg[4], cfg[2], cfg[1:0], 1'b0});
		end
		// sync output off releases the pin
		host.wr(RCS_RESP_CTL_ADDR, 32'h0000_0002);
		repeat (3) @(negedge clk);
		chk({g3oe, g3}, 32'h0);
		summarize();
	end
endmodule : rcs_top_tb
